// >>> hw/dag_map.vh
`ifndef DAG_MAP_VH
`define DAG_MAP_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DAG_CTRL_OFS    8'h00
`define DAG_BOUNDS_OFS  8'h04
`define DAG_CMD_OFS     8'h08
`define DAG_STAT_OFS    8'h0C
`define DAG_XADDR_OFS   8'h10
`define DAG_YADDR_OFS   8'h14
`define DAG_MADDR_OFS   8'h18
`define DAG_PTR_TAG     3'h1
// ---------------------------------------------------------------
// Command fields
// ---------------------------------------------------------------
`define DAG_OP          1:0
`define DAG_OP_NONE     2'h0
`define DAG_OP_DUAL     2'h1
`define DAG_OP_WORD     2'h2
`define DAG_OP_LONG     2'h3
`define DAG_X_EN        2
`define DAG_X_SEL       3
`define DAG_X_MODE      5:4
`define DAG_X_WR        6
`define DAG_X_OPD       7
`define DAG_Y_EN        8
`define DAG_Y_SEL       9
`define DAG_Y_MODE      11:10
`define DAG_Y_WR        12
`define DAG_Y_OPD       13
`define DAG_S_SEL       17:16
`define DAG_S_MODE      19:18
`define DAG_S_WR        20
`define DAG_S_OPD       24:21
// ---------------------------------------------------------------
// Pointer modes, steps and register slots
// ---------------------------------------------------------------
`define DAG_M_PREDEC    2'h0
`define DAG_M_NOP       2'h1
`define DAG_M_INC       2'h2
`define DAG_M_INDEX     2'h3
`define DAG_STEP_WORD   32'h0000_0002
`define DAG_STEP_LONG   32'h0000_0004
`define DAG_SLOT_R4     3'h2
`define DAG_SLOT_R6     3'h4
`define DAG_SLOT_R8     3'h6
`define DAG_SLOT_R9     3'h7
`define DAG_DS_A1       4'h5
`define DAG_DS_RSV6     4'h6
// ---------------------------------------------------------------
// Control and status bits, reset values
// ---------------------------------------------------------------
`define DAG_CTRL_XCE    0
`define DAG_CTRL_YCE    1
`define DAG_STAT_RSV    0
`define DAG_STAT_DUAL   1
`define DAG_STAT_SING   2
`define DAG_ZERO32      32'h0000_0000
`endif

// >>> hw/dag_xy_update.v
`include "dag_map.vh"
// Pointer unit for one X or Y word pointer of a dual transfer.
module dag_xy_update #(
  parameter LOW_ONLY = 0            // Keep the upper word on update.
) (
  ptr,                              // Pointer before update.
  index,                            // Index register value.
  mode,                             // Pointer mode.
  circ,                             // Circular mode active.
  bounds,                           // End in upper, start in lower half.
  addr,                             // Access address, bit 0 zero.
  new_ptr                           // Pointer after update.
);
  input  wire [31:0] ptr;
  input  wire [31:0] index;
  input  wire [1:0]  mode;
  input  wire        circ;
  input  wire [31:0] bounds;
  output wire [15:0] addr;
  output reg  [31:0] new_ptr;

  reg  [31:0] step;
  reg  [31:0] sum;
  wire        hit;

  // Only bits 15..1 leave on the X/Y bus; bit 0 is disregarded.
  assign addr = {ptr[15:1], 1'b0};
  // An exact match with the end value is needed; stepping past it
  // keeps the linear result.
  assign hit  = (ptr[15:1] == bounds[31:17]);

  // ---------------------------------------------------------------
  // Update
  // ---------------------------------------------------------------
  // Post update: increment by 2, add index, or leave unchanged.
  always @* begin
    case (mode)
      `DAG_M_INC:   step = `DAG_STEP_WORD;
      `DAG_M_INDEX: step = index;
      default:      step = `DAG_ZERO32;
    endcase
    sum = ptr + step;
    // Only updating modes wrap; the pre-decrement code is a no-update here.
    if (circ && (mode == `DAG_M_INC || mode == `DAG_M_INDEX) && hit) begin
      new_ptr = {ptr[31:16], bounds[15:1], ptr[0]};
    end else if (LOW_ONLY != 0) begin
      new_ptr = {ptr[31:16], sum[15:0]};
    end else begin
      new_ptr = sum;
    end
  end
endmodule

// >>> hw/dag_single_update.v
`include "dag_map.vh"
// Pointer unit for single word or longword transfers; always linear.
module dag_single_update (
  ptr,                              // Pointer before update.
  index,                            // Index register value.
  mode,                             // Pointer mode.
  long,                             // Longword transfer.
  addr,                             // Access address.
  new_ptr                           // Pointer after update.
);
  input  wire [31:0] ptr;
  input  wire [31:0] index;
  input  wire [1:0]  mode;
  input  wire        long;
  output reg  [31:0] addr;
  output reg  [31:0] new_ptr;

  wire [31:0] size;

  assign size = long ? `DAG_STEP_LONG : `DAG_STEP_WORD;

  // ---------------------------------------------------------------
  // Update
  // ---------------------------------------------------------------
  // Pre-decrement addresses with the new value, others with the old.
  always @* begin
    addr = ptr;
    case (mode)
      `DAG_M_PREDEC: begin
        new_ptr = ptr - size;
        addr    = new_ptr;
      end
      `DAG_M_INC:   new_ptr = ptr + size;
      `DAG_M_INDEX: new_ptr = ptr + index;
      default:      new_ptr = ptr;
    endcase
  end
endmodule

// >>> hw/dag_top.v
`include "dag_map.vh"
module dag_top (
  hclk,                             // System clock.
  hresetn,                          // Asynchronous reset, active low.
  hsel,                             // Slave select.
  haddr,                            // Byte address.
  htrans,                           // Transfer type.
  hwrite,                           // Write when high.
  hsize,                            // Transfer size, words only.
  hwdata,                           // Write data.
  hready,                           // Bus ready in.
  hreadyout,                        // Slave ready out.
  hresp,                            // Response, always okay.
  hrdata,                           // Read data.
  x_bus_req,                        // X data bus access pulse.
  x_bus_write,                      // X access is a store.
  x_access_address,                 // X data bus address.
  x_operand_sel,                    // X0/X1 load or A0/A1 store.
  y_bus_req,                        // Y data bus access pulse.
  y_bus_write,                      // Y access is a store.
  y_access_address,                 // Y data bus address.
  y_operand_sel,                    // Y0/Y1 load or A0/A1 store.
  cpu_bus_req,                      // CPU data bus access pulse.
  cpu_bus_write,                    // CPU access is a store.
  cpu_bus_long,                     // Longword when high.
  main_access_address,              // CPU data bus address.
  single_operand_sel                // DSP register code.
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output reg         hreadyout;
  output reg         hresp;
  output reg  [31:0] hrdata;
  output reg         x_bus_req;
  output reg         x_bus_write;
  output reg  [15:0] x_access_address;
  output reg         x_operand_sel;
  output reg         y_bus_req;
  output reg         y_bus_write;
  output reg  [15:0] y_access_address;
  output reg         y_operand_sel;
  output reg         cpu_bus_req;
  output reg         cpu_bus_write;
  output reg         cpu_bus_long;
  output reg  [31:0] main_access_address;
  output reg  [3:0]  single_operand_sel;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Pointer window decode, shared by read and write paths.
  function is_ptr;
    input [7:0] a;
    begin
      is_ptr = (a[7:5] == `DAG_PTR_TAG);
    end
  endfunction

  // Codes marked system reserved for the single operand.
  function ds_reserved;
    input [3:0] c;
    begin
      ds_reserved = (c < `DAG_DS_A1) || (c == `DAG_DS_RSV6);
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg  [31:0] ptr_reg [0:7];        // R2..R9 copy, slot = n - 2.
  reg  [1:0]  ctrl_reg;
  reg  [31:0] bounds_reg;
  reg  [2:0]  stat_reg;
  reg         dph_wr_reg;
  reg  [7:0]  dph_addr_reg;
  reg  [31:0] rd_next;
  integer     i;

  wire        acc;
  wire        wr_cmd;
  wire [31:0] cmd;
  wire        dual_go;
  wire        sing_go;
  wire        sing_ok;
  wire        x_circ;
  wire        y_circ;
  wire [2:0]  x_slot;
  wire [2:0]  y_slot;
  wire [2:0]  s_slot;
  wire [15:0] x_addr;
  wire [15:0] y_addr;
  wire [31:0] s_addr;
  wire [31:0] x_new;
  wire [31:0] y_new;
  wire [31:0] s_new;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // A command write is one execute cycle; the pointers it touches are
  // written back on the same edge, so the next command sees them.
  assign acc     = hsel && htrans[1] && hready;
  assign wr_cmd  = dph_wr_reg && (dph_addr_reg == `DAG_CMD_OFS);
  assign cmd     = hwdata;
  assign dual_go = wr_cmd && (cmd[`DAG_OP] == `DAG_OP_DUAL);
  assign sing_go = wr_cmd && (cmd[`DAG_OP] == `DAG_OP_WORD
                              || cmd[`DAG_OP] == `DAG_OP_LONG);
  assign sing_ok = sing_go && !ds_reserved(cmd[`DAG_S_OPD]);
  // With both enables set only Y wraps; single moves never wrap.
  assign x_circ  = ctrl_reg[`DAG_CTRL_XCE]
                   && !ctrl_reg[`DAG_CTRL_YCE];
  assign y_circ  = ctrl_reg[`DAG_CTRL_YCE];
  assign x_slot  = `DAG_SLOT_R4 + {2'h0, cmd[`DAG_X_SEL]};
  assign y_slot  = `DAG_SLOT_R6 + {2'h0, cmd[`DAG_Y_SEL]};
  // Select 0..3 picks R4, R5, R2, R3.
  assign s_slot  = {1'b0, ~cmd[17], cmd[16]};

  // ---------------------------------------------------------------
  // Pointer units
  // ---------------------------------------------------------------
  dag_xy_update #(.LOW_ONLY(0)) u_x (
    .ptr     (ptr_reg[x_slot]),
    .index   (ptr_reg[`DAG_SLOT_R8]),
    .mode    (cmd[`DAG_X_MODE]),
    .circ    (x_circ),
    .bounds  (bounds_reg),
    .addr    (x_addr),
    .new_ptr (x_new)
  );

  dag_xy_update #(.LOW_ONLY(1)) u_y (
    .ptr     (ptr_reg[y_slot]),
    .index   (ptr_reg[`DAG_SLOT_R9]),
    .mode    (cmd[`DAG_Y_MODE]),
    .circ    (y_circ),
    .bounds  (bounds_reg),
    .addr    (y_addr),
    .new_ptr (y_new)
  );

  dag_single_update u_s (
    .ptr     (ptr_reg[s_slot]),
    .index   (ptr_reg[`DAG_SLOT_R8]),
    .mode    (cmd[`DAG_S_MODE]),
    .long    (cmd[0]),
    .addr    (s_addr),
    .new_ptr (s_new)
  );

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Read data is fetched in the address phase so it stands for the
  // whole data phase; the slave never inserts wait states.
  always @* begin
    rd_next = `DAG_ZERO32;
    if (is_ptr(haddr[7:0])) begin
      rd_next = ptr_reg[haddr[4:2]];
    end else begin
      case (haddr[7:0])
        `DAG_CTRL_OFS:   rd_next = {30'h0, ctrl_reg};
        `DAG_BOUNDS_OFS: rd_next = bounds_reg;
        `DAG_STAT_OFS:   rd_next = {29'h0, stat_reg};
        `DAG_XADDR_OFS:  rd_next = {16'h0, x_access_address};
        `DAG_YADDR_OFS:  rd_next = {16'h0, y_access_address};
        `DAG_MADDR_OFS:  rd_next = main_access_address;
        default:         rd_next = `DAG_ZERO32;
      endcase
    end
  end

  // Address phase capture and registered read data.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= 8'h00;
      hrdata       <= `DAG_ZERO32;
      hreadyout    <= 1'b0;
      hresp        <= 1'b0;
    end else begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      dph_wr_reg   <= acc && hwrite;
      if (acc) begin
        dph_addr_reg <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control, bounds and status registers
  // ---------------------------------------------------------------
  // Software loads end:start as one word, then sets an enable. The
  // sticky reserved-code flag clears by writing one; a new reserved
  // code in the same cycle wins over the clear.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= 2'h0;
      bounds_reg <= `DAG_ZERO32;
      stat_reg   <= 3'h0;
    end else begin
      if (dph_wr_reg && dph_addr_reg == `DAG_CTRL_OFS) begin
        ctrl_reg <= hwdata[1:0];
      end
      if (dph_wr_reg && dph_addr_reg == `DAG_BOUNDS_OFS) begin
        bounds_reg <= hwdata;
      end
      if (sing_go && !sing_ok) begin
        stat_reg[`DAG_STAT_RSV] <= 1'b1;
      end else if (dph_wr_reg && dph_addr_reg == `DAG_STAT_OFS
                   && hwdata[`DAG_STAT_RSV]) begin
        stat_reg[`DAG_STAT_RSV] <= 1'b0;
      end
      if (dual_go || sing_ok) begin
        stat_reg[`DAG_STAT_DUAL] <= dual_go;
        stat_reg[`DAG_STAT_SING] <= sing_ok;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pointer file and write-back
  // ---------------------------------------------------------------
  // X and Y slots never coincide, so both may retire together.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        ptr_reg[i] <= `DAG_ZERO32;
      end
    end else begin
      if (dph_wr_reg && is_ptr(dph_addr_reg)) begin
        ptr_reg[dph_addr_reg[4:2]] <= hwdata;
      end
      if (dual_go && cmd[`DAG_X_EN]) begin
        ptr_reg[x_slot] <= x_new;
      end
      if (dual_go && cmd[`DAG_Y_EN]) begin
        ptr_reg[y_slot] <= y_new;
      end
      if (sing_ok) begin
        ptr_reg[s_slot] <= s_new;
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory access outputs
  // ---------------------------------------------------------------
  // Requests are one-cycle pulses; addresses and selects hold until
  // the next access of their bus.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_bus_req           <= 1'b0;
      x_bus_write         <= 1'b0;
      x_access_address    <= 16'h0000;
      x_operand_sel       <= 1'b0;
      y_bus_req           <= 1'b0;
      y_bus_write         <= 1'b0;
      y_access_address    <= 16'h0000;
      y_operand_sel       <= 1'b0;
      cpu_bus_req         <= 1'b0;
      cpu_bus_write       <= 1'b0;
      cpu_bus_long        <= 1'b0;
      main_access_address <= `DAG_ZERO32;
      single_operand_sel  <= 4'h0;
    end else begin
      x_bus_req   <= dual_go && cmd[`DAG_X_EN];
      y_bus_req   <= dual_go && cmd[`DAG_Y_EN];
      cpu_bus_req <= sing_ok;
      if (dual_go && cmd[`DAG_X_EN]) begin
        x_access_address <= x_addr;
        x_bus_write      <= cmd[`DAG_X_WR];
        x_operand_sel    <= cmd[`DAG_X_OPD];
      end
      if (dual_go && cmd[`DAG_Y_EN]) begin
        y_access_address <= y_addr;
        y_bus_write      <= cmd[`DAG_Y_WR];
        y_operand_sel    <= cmd[`DAG_Y_OPD];
      end
      if (sing_ok) begin
        main_access_address <= s_addr;
        cpu_bus_write       <= cmd[`DAG_S_WR];
        cpu_bus_long        <= cmd[0];
        single_operand_sel  <= cmd[`DAG_S_OPD];
      end
    end
  end
endmodule

// >>> tb/dag_mem_model.sv
// ---------------------------------------------------------------
// Data memory side: counts accesses on the X, Y and CPU buses
// ---------------------------------------------------------------
module dag_mem_model (
  hclk,                             // System clock.
  hresetn,                          // Reset, active low.
  x_req,                            // X bus access pulse.
  y_req,                            // Y bus access pulse.
  c_req,                            // CPU bus access pulse.
  n_x,                              // X accesses seen.
  n_y,                              // Y accesses seen.
  n_c                               // CPU accesses seen.
);
  timeunit 1ns;
  timeprecision 1ps;
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        x_req;
  input  wire        y_req;
  input  wire        c_req;
  output reg  [15:0] n_x;
  output reg  [15:0] n_y;
  output reg  [15:0] n_c;
  // Every pulse is one word or longword access, so counting them shows lost or extra accesses.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_x <= 16'h0000;
      n_y <= 16'h0000;
      n_c <= 16'h0000;
    end else begin
      n_x <= n_x + {15'h0000, x_req};
      n_y <= n_y + {15'h0000, y_req};
      n_c <= n_c + {15'h0000, c_req};
    end
  end
endmodule

// >>> tb/dag_top_chk.sv
`include "dag_map.vh"
module dag_top_chk (
  hclk,                             // System clock.
  hresetn,                          // Reset, active low.
  hsel,                             // Slave select.
  haddr,                            // Byte address.
  htrans,                           // Transfer type.
  hwrite,                           // Write when high.
  hready,                           // Bus ready in.
  hreadyout,                        // Slave ready out.
  hresp,                            // Response.
  x_bus_req,                        // X access pulse.
  x_access_address,                 // X address.
  y_bus_req,                        // Y access pulse.
  y_access_address,                 // Y address.
  cpu_bus_req,                      // CPU access pulse.
  main_access_address,              // CPU address.
  single_operand_sel                // DSP register code.
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire        hclk;
  input wire        hresetn;
  input wire        hsel;
  input wire [31:0] haddr;
  input wire [1:0]  htrans;
  input wire        hwrite;
  input wire        hready;
  input wire        hreadyout;
  input wire        hresp;
  input wire        x_bus_req;
  input wire [15:0] x_access_address;
  input wire        y_bus_req;
  input wire [15:0] y_access_address;
  input wire        cpu_bus_req;
  input wire [31:0] main_access_address;
  input wire [3:0]  single_operand_sel;
  reg cmd_ph;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // Helper: a command write is in its data phase
  // ---------------------------------------------------------------
  // Remembers the address phase so a pulse can be tied back to its cause.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_ph <= 1'b0;
    else cmd_ph <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == `DAG_CMD_OFS);
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  property p_xbit0; x_bus_req |-> x_access_address[0] == 1'b0; endproperty
  a_xbit0: assert property (p_xbit0) else $error("x address bit 0 set");
  property p_ybit0; y_bus_req |-> y_access_address[0] == 1'b0; endproperty
  a_ybit0: assert property (p_ybit0) else $error("y address bit 0 set");
  property p_excl; cpu_bus_req |-> !x_bus_req && !y_bus_req; endproperty
  a_excl: assert property (p_excl) else $error("single and dual access together");
  property p_opsel; cpu_bus_req |-> single_operand_sel == 4'h5 || single_operand_sel >= 4'h7; endproperty
  a_opsel: assert property (p_opsel) else $error("reserved operand issued");
  property p_cause; x_bus_req || y_bus_req || cpu_bus_req |-> $past(cmd_ph); endproperty
  a_cause: assert property (p_cause) else $error("access without command");
  property p_xhold; !x_bus_req |-> $stable(x_access_address); endproperty
  a_xhold: assert property (p_xhold) else $error("x address moved idle");
  property p_mhold; !cpu_bus_req |-> $stable(main_access_address); endproperty
  a_mhold: assert property (p_mhold) else $error("main address moved idle");
endmodule
bind dag_top dag_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .x_bus_req(x_bus_req),
  .x_access_address(x_access_address), .y_bus_req(y_bus_req), .y_access_address(y_access_address),
  .cpu_bus_req(cpu_bus_req), .main_access_address(main_access_address), .single_operand_sel(single_operand_sel));

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg  [31:0] haddr = 0, hwdata = 0, rd, bnd, c;
  reg  [1:0]  htrans = 0, ctl;
  reg  [2:0]  hsize = 3'h2;
  wire        rdy, resp, xr, xw, xo, yr, yw, yo, cr, cw, cl;
  wire [31:0] hrdata, ma;
  wire [15:0] xa, ya, n_x, n_y, n_c;
  wire [3:0]  so;
  reg  [31:0] rf [2:9];
  integer     n_fail = 0, check_count = 0, seed = 32'hc8b9, i, k, ex_x = 0, ex_y = 0, ex_c = 0;
  reg         st0 = 0;
  dag_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(resp), .hrdata(hrdata),
    .x_bus_req(xr), .x_bus_write(xw), .x_access_address(xa), .x_operand_sel(xo), .y_bus_req(yr),
    .y_bus_write(yw), .y_access_address(ya), .y_operand_sel(yo), .cpu_bus_req(cr), .cpu_bus_write(cw),
    .cpu_bus_long(cl), .main_access_address(ma), .single_operand_sel(so));
  dag_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .x_req(xr), .y_req(yr), .c_req(cr),
    .n_x(n_x), .n_y(n_y), .n_c(n_c));
  // Free-running 100 MHz clock.
  always #5 hclk = ~hclk;
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task summarize;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait for hready, so a stuck slave ends the run instead of hanging it.
  task wait_rdy;
    integer w;
    w = 0;
    @(posedge hclk);
    while (rdy !== 1'b1) begin
      w = w + 1;
      if (w > 20) begin
        n_fail = n_fail + 1;
        summarize;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input wr, input [31:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // ---------------------------------------------------------------
  // Expected pointer arithmetic
  // ---------------------------------------------------------------
  // Dual update: Y keeps its upper word, a wrap needs an exact end match.
  function [31:0] dual_new(input [31:0] p, input [31:0] ix, input [1:0] m, input circ, input lo);
    reg [31:0] s;
    begin
      s = p + (m == 2'h2 ? 32'h2 : (m == 2'h3 ? ix : 32'h0));
      if (lo) s = {p[31:16], s[15:0]};
      if (circ && m[1] && p[15:1] == bnd[31:17]) s = {p[31:16], bnd[15:1], p[0]};
      dual_new = s;
    end
  endfunction
  function [31:0] sing_new(input [31:0] p, input [1:0] m, input l);
    sing_new = m == 2'h0 ? p - (l ? 32'h4 : 32'h2) : m == 2'h1 ? p : m == 2'h2 ? p + (l ? 32'h4 : 32'h2) : p + rf[8];
  endfunction
  // One command, checked at the ports and by reading the pointers back.
  task cmd(input [31:0] v);
    reg [31:0] xp, yp, sp, xn, yn, sn;
    integer xs, ys, ss;
    reg ok;
    xs = 4 + v[3];
    ys = 6 + v[9];
    ss = v[17] ? 2 + v[16] : 4 + v[16];
    xp = rf[xs];
    yp = rf[ys];
    sp = rf[ss];
    ok = v[24:21] == 4'h5 || v[24:21] >= 4'h7;
    xn = v[2] ? dual_new(xp, rf[8], v[5:4], ctl == 2'h1, 1'b0) : xp;
    yn = v[8] ? dual_new(yp, rf[9], v[11:10], ctl[1], 1'b1) : yp;
    sn = sing_new(sp, v[19:18], v[0]);
    bus(1'b1, 32'h08, v);
    #1;
    if (v[1:0] == 2'h1) begin
      chk(xr, v[2]);
      chk(yr, v[8]);
      chk(cr, 0);
      if (v[2]) chk({xa, xw, xo}, {xp[15:1], 1'b0, v[6], v[7]});
      if (v[8]) chk({ya, yw, yo}, {yp[15:1], 1'b0, v[12], v[13]});
      ex_x = ex_x + v[2];
      ex_y = ex_y + v[8];
      rf[xs] = xn;
      rf[ys] = yn;
      bus(1'b0, 32'h18 + 4 * xs, 0);
      chk(rd, xn);
      bus(1'b0, 32'h18 + 4 * ys, 0);
      chk(rd, yn);
    end else begin
      chk({xr, yr, cr}, {2'b00, ok});
      if (ok) chk(ma, v[19:18] == 2'h0 ? sn : sp);
      if (ok) chk({cw, cl, so}, {v[20], v[0], v[24:21]});
      if (ok) rf[ss] = sn;
      ex_c = ex_c + ok;
      if (!ok) st0 = 1'b1;
      bus(1'b0, 32'h18 + 4 * ss, 0);
      chk(rd, rf[ss]);
      bus(1'b0, 32'h0C, 0);
      chk(rd[0], st0);
      if (ok) chk(rd[2:1], 2'b10);
      if (st0) bus(1'b1, 32'h0C, 1);
      st0 = 1'b0;
    end
  endtask
  task setr(input integer n, input [31:0] v);
    rf[n] = v;
    bus(1'b1, 32'h18 + 4 * n, v);
  endtask
  task setc(input [1:0] v, input [31:0] b);
    ctl = v;
    bnd = b;
    bus(1'b1, 32'h00, v);
    bus(1'b1, 32'h04, b);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Everything reads zero after reset, including the unmapped word at 0x40.
    for (k = 0; k <= 16; k = k + 1) begin
      bus(1'b0, 4 * k, 0);
      chk(rd, 0);
    end
    for (k = 2; k <= 9; k = k + 1) setr(k, $random(seed) & 32'hFFFF_FFFE);
    // X wraps from the end back to the start, upper word untouched.
    setc(2'h1, 32'hE00C_E008);
    bus(1'b0, 32'h04, 0);
    chk(rd, bnd);
    setr(4, 32'h1000_E008);
    for (k = 0; k < 3; k = k + 1) cmd(32'h25);
    // Both enables set: Y wraps, X stays linear.
    setc(2'h3, 32'hE00C_E008);
    setr(6, 32'h2000_E008);
    for (k = 0; k < 3; k = k + 1) cmd(32'h925);
    // Index steps over the end without matching it, and a step of -2 goes down.
    setr(9, 32'h6);
    setr(8, 32'hFFFF_FFFE);
    cmd(32'hD01);
    cmd(32'hD35);
    // Every reserved operand code is refused.
    for (k = 0; k < 7; k = k + 1) if (k != 5) cmd(32'h2 | (k << 21) | ($random(seed) & 32'hC_0000));
    // Random mix; single transfers must ignore the circular enables.
    for (i = 0; i < 80; i = i + 1) begin
      setc($random(seed), {$random(seed)} & 32'hFFFE_FFFE);
      if (i % 8 == 0) setr(8, $random(seed) & 32'hFFFF_FFFE);
      c = $random(seed);
      if (c[1:0] == 2'h0) c[0] = 1'b1;
      cmd(c);
    end
    chk({n_x, n_y}, {ex_x[15:0], ex_y[15:0]});
    chk(n_c, ex_c[15:0]);
    summarize;
  end
endmodule
